// ---- hw/lec1_regs.svh ----
// Register map, field positions and reset values of the lookup engine control block.
// Function
// RULE1: When control bit 7 is one the block stops learning unicast source addresses, and learning runs while it is zero, its reset value.
// RULE2: With self-address filtering active, a received frame whose source address equals the six-byte switch address is dropped.
// RULE3: Self-address filtering acts only on ports whose own enable is set while global bit 6 is one, and on no port while bit 6 is zero.
// RULE4: Writing one to bit 5 starts a flush of the whole lookup table and the bit then clears itself, while writing zero changes nothing.
// RULE5: Both flush triggers remove only the kind of entries chosen by the separate flush option field.
// RULE6: The flush option codes are 00 none or done, 01 dynamic only, 10 static only and 11 both.
// RULE7: Writing one to bit 4 starts a flush of the entries matching the spanning-tree instance and the bit then clears itself.
// RULE8: While bit 3 is zero frames with a multicast source address are dropped, and at its reset value one they are forwarded.
// RULE9: Bit 2, reset to one, enables table aging, and clearing it stops aging.
// RULE10: While bit 1 is one the table uses fast aging instead of the normal interval, and its reset value is zero.
// RULE11: While bit 0 is one a link-down on any port flushes that port's entries, and while it is zero no such flush occurs.
// RULE12: A flush bit started through bit 5 or bit 4 reads one until its flush has completed and zero afterwards.
`ifndef LEC1_REGS_SVH
`define LEC1_REGS_SVH

`define LEC1_ADDR_W 16
`define LEC1_ADDR_CTRL1 16'h0311
`define LEC1_ADDR_CTRL2 16'h0312
`define LEC1_CTRL1_RST 8'h0c
`define LEC1_BIT_LEARN_DIS 7
`define LEC1_BIT_SELF_FILT 6
`define LEC1_BIT_FLUSH_ALL 5
`define LEC1_BIT_FLUSH_MSTP 4
`define LEC1_BIT_MC_FWD 3
`define LEC1_BIT_AGE_EN 2
`define LEC1_BIT_FAST_AGE 1
`define LEC1_BIT_LINK_FLUSH 0
`define LEC1_OPT_LSB 2
`define LEC1_OPT_MSB 3
`define LEC1_OPT_NONE 2'h0
`define LEC1_OPT_DYN 2'h1
`define LEC1_OPT_STAT 2'h2
`define LEC1_OPT_BOTH 2'h3
`define LEC1_NPORTS 3
`define LEC1_SA_MC_BIT 40

`endif

// ---- hw/lec1_pkg.sv ----
// Types shared by the lookup engine control block and its users.
package lec1_pkg;

   typedef struct packed {
      logic valid;
      logic [47:0] sa;
      logic [1:0] port;
   } lec1_frame_t;

   typedef enum logic [2:0] {
      LEC1_K_ALL = 3'b001,
      LEC1_K_MSTP = 3'b010,
      LEC1_K_PORT = 3'b100
   } lec1_kind_t;

   typedef struct packed {
      lec1_kind_t kind;
      logic [1:0] opt;
      logic [2:0] ports;
   } lec1_flush_cmd_t;

   typedef enum logic [1:0] {
      LEC1_ST_IDLE = 2'b01,
      LEC1_ST_BUSY = 2'b10
   } lec1_st_t;

endpackage

// ---- hw/lec1_ctrl.sv ----
// Lookup engine control register with frame filter, aging controls and flush sequencer.
//
// Decided for this implementation: the address-and-strobe port.
`timescale 1ns/1ps
`include "lec1_regs.svh"

module lec1_ctrl (
   input wire logic i_clk,
   input wire logic i_rst_b,
   input wire logic [15:0] i_addr,
   input wire logic [7:0] i_wdata,
   input wire logic i_wr,
   input wire logic i_rd,
   output logic [7:0] o_rdata,
   input wire lec1_pkg::lec1_frame_t i_frame,
   input wire logic [47:0] i_switch_mac,
   input wire logic [2:0] i_port_self_filt_en,
   input wire logic [2:0] i_link_up,
   input wire logic i_flush_done,
   output logic o_drop,
   output logic o_learn,
   output logic o_age_en,
   output logic o_fast_age,
   output logic o_flush_start,
   output lec1_pkg::lec1_flush_cmd_t o_flush_cmd
);

   // ****************************************
   // Register access
   // ****************************************
   function automatic logic hit(input logic [15:0] a, input logic [15:0] reg_addr);
      hit = (a == reg_addr);
   endfunction

   logic [7:0] ctrl_ff;
   logic [7:0] nxt_ctrl;
   logic [1:0] opt_ff;
   logic [1:0] nxt_opt;
   logic [7:0] rdata_ff;
   logic [7:0] nxt_rdata;
   logic all_pend_ff;
   logic nxt_all_pend;
   logic mstp_pend_ff;
   logic nxt_mstp_pend;
   logic [2:0] port_pend_ff;
   logic [2:0] nxt_port_pend;
   logic wr_ctrl1;
   logic clr_all;
   logic clr_mstp;
   logic [2:0] clr_ports;
   logic [2:0] link_down;

   assign wr_ctrl1 = i_wr && hit(i_addr, `LEC1_ADDR_CTRL1);

   always_comb begin
      nxt_ctrl = ctrl_ff;
      nxt_opt = opt_ff;
      nxt_rdata = 8'h00;
      if (wr_ctrl1) begin
         // Trigger bits are not stored here; they live in the pending flags.
         nxt_ctrl = i_wdata;
         nxt_ctrl[`LEC1_BIT_FLUSH_ALL] = 1'b0;
         nxt_ctrl[`LEC1_BIT_FLUSH_MSTP] = 1'b0;
      end
      if (i_wr && hit(i_addr, `LEC1_ADDR_CTRL2)) begin
         nxt_opt = i_wdata[`LEC1_OPT_MSB:`LEC1_OPT_LSB]; // RULE6
      end
      if (i_rd && hit(i_addr, `LEC1_ADDR_CTRL1)) begin
         nxt_rdata = ctrl_ff;
         nxt_rdata[`LEC1_BIT_FLUSH_ALL] = all_pend_ff; // RULE12
         nxt_rdata[`LEC1_BIT_FLUSH_MSTP] = mstp_pend_ff; // RULE12
      end else if (i_rd && hit(i_addr, `LEC1_ADDR_CTRL2)) begin
         nxt_rdata[`LEC1_OPT_MSB:`LEC1_OPT_LSB] = opt_ff;
      end
   end

   // A trigger that lands in the cycle its flush completes starts a new flush.
   always_comb begin
      nxt_all_pend = (all_pend_ff && !clr_all) ||
                     (wr_ctrl1 && i_wdata[`LEC1_BIT_FLUSH_ALL]); // RULE4
      nxt_mstp_pend = (mstp_pend_ff && !clr_mstp) ||
                      (wr_ctrl1 && i_wdata[`LEC1_BIT_FLUSH_MSTP]); // RULE7
      nxt_port_pend = (port_pend_ff & ~clr_ports) |
                      (link_down & {`LEC1_NPORTS{ctrl_ff[`LEC1_BIT_LINK_FLUSH]}}); // RULE11
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ctrl_ff <= `LEC1_CTRL1_RST;
         opt_ff <= `LEC1_OPT_NONE;
         rdata_ff <= 8'h00;
         all_pend_ff <= 1'b0;
         mstp_pend_ff <= 1'b0;
         port_pend_ff <= 3'h0;
      end else begin
         ctrl_ff <= nxt_ctrl;
         opt_ff <= nxt_opt;
         rdata_ff <= nxt_rdata;
         all_pend_ff <= nxt_all_pend;
         mstp_pend_ff <= nxt_mstp_pend;
         port_pend_ff <= nxt_port_pend;
      end
   end

   assign o_rdata = rdata_ff;
   assign o_age_en = ctrl_ff[`LEC1_BIT_AGE_EN]; // RULE9
   assign o_fast_age = ctrl_ff[`LEC1_BIT_FAST_AGE]; // RULE10

   // ****************************************
   // Link status synchroniser
   // ****************************************
   // A port counts as down only once two late stages agree, which filters glitches.
   logic [2:0] ls1_ff;
   logic [2:0] ls2_ff;
   logic [2:0] ls3_ff;
   logic [2:0] link_ff;
   logic [2:0] nxt_link;

   genvar gp;
   generate
      for (gp = 0; gp < `LEC1_NPORTS; gp++) begin : g_link
         always_comb begin
            nxt_link[gp] = (ls2_ff[gp] == ls3_ff[gp]) ? ls3_ff[gp] : link_ff[gp];
            link_down[gp] = link_ff[gp] && !nxt_link[gp];
         end
      end
   endgenerate

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         ls1_ff <= 3'h0;
         ls2_ff <= 3'h0;
         ls3_ff <= 3'h0;
         link_ff <= 3'h0;
      end else begin
         ls1_ff <= i_link_up;
         ls2_ff <= ls1_ff;
         ls3_ff <= ls2_ff;
         link_ff <= nxt_link;
      end
   end

   // ****************************************
   // Flush sequencer
   // ****************************************
   // Only one flush runs at a time; whole table first, then spanning tree, then ports.
   lec1_pkg::lec1_st_t st_ff;
   lec1_pkg::lec1_st_t nxt_st;
   lec1_pkg::lec1_flush_cmd_t cmd_ff;
   lec1_pkg::lec1_flush_cmd_t nxt_cmd;
   logic start_ff;
   logic nxt_start;
   logic opt_none;

   assign opt_none = (opt_ff == `LEC1_OPT_NONE);

   always_comb begin
      nxt_st = st_ff;
      nxt_cmd = cmd_ff;
      nxt_start = 1'b0;
      clr_all = 1'b0;
      clr_mstp = 1'b0;
      clr_ports = 3'h0;
      case (st_ff)
         lec1_pkg::LEC1_ST_IDLE: begin
            // With option none there is nothing to remove, so the trigger retires at once.
            nxt_cmd.opt = opt_ff; // RULE5
            if (all_pend_ff) begin
               nxt_cmd.kind = lec1_pkg::LEC1_K_ALL;
               nxt_cmd.ports = 3'h0;
               clr_all = opt_none; // RULE5
            end else if (mstp_pend_ff) begin
               nxt_cmd.kind = lec1_pkg::LEC1_K_MSTP;
               nxt_cmd.ports = 3'h0;
               clr_mstp = opt_none; // RULE5
            end else if (|port_pend_ff) begin
               nxt_cmd.kind = lec1_pkg::LEC1_K_PORT;
               nxt_cmd.ports = port_pend_ff;
               clr_ports = opt_none ? port_pend_ff : 3'h0;
            end
            if ((all_pend_ff || mstp_pend_ff || (|port_pend_ff)) && !opt_none) begin
               nxt_start = 1'b1;
               nxt_st = lec1_pkg::LEC1_ST_BUSY;
            end
         end
         lec1_pkg::LEC1_ST_BUSY: begin
            if (i_flush_done) begin
               clr_all = (cmd_ff.kind == lec1_pkg::LEC1_K_ALL); // RULE4
               clr_mstp = (cmd_ff.kind == lec1_pkg::LEC1_K_MSTP); // RULE7
               clr_ports = (cmd_ff.kind == lec1_pkg::LEC1_K_PORT) ? cmd_ff.ports : 3'h0;
               nxt_st = lec1_pkg::LEC1_ST_IDLE;
            end
         end
         default: begin
            nxt_st = lec1_pkg::LEC1_ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         st_ff <= lec1_pkg::LEC1_ST_IDLE;
         cmd_ff <= '{kind: lec1_pkg::LEC1_K_ALL, opt: `LEC1_OPT_NONE, ports: 3'h0};
         start_ff <= 1'b0;
      end else begin
         st_ff <= nxt_st;
         cmd_ff <= nxt_cmd;
         start_ff <= nxt_start;
      end
   end

   assign o_flush_start = start_ff;
   assign o_flush_cmd = cmd_ff;

   // ****************************************
   // Frame filter and learning
   // ****************************************
   logic drop_ff;
   logic nxt_drop;
   logic learn_ff;
   logic nxt_learn;
   logic sa_mc;
   logic self_hit;

   always_comb begin
      sa_mc = i_frame.sa[`LEC1_SA_MC_BIT];
      self_hit = ctrl_ff[`LEC1_BIT_SELF_FILT] && i_port_self_filt_en[i_frame.port] &&
                 (i_frame.sa == i_switch_mac); // RULE2 RULE3
      nxt_drop = i_frame.valid &&
                 (self_hit || (sa_mc && !ctrl_ff[`LEC1_BIT_MC_FWD])); // RULE8
      nxt_learn = i_frame.valid && !nxt_drop && !sa_mc &&
                  !ctrl_ff[`LEC1_BIT_LEARN_DIS]; // RULE1
   end

   always_ff @(posedge i_clk or negedge i_rst_b) begin
      if (!i_rst_b) begin
         drop_ff <= 1'b0;
         learn_ff <= 1'b0;
      end else begin
         drop_ff <= nxt_drop;
         learn_ff <= nxt_learn;
      end
   end

   assign o_drop = drop_ff;
   assign o_learn = learn_ff;

   // ****************************************
   // Assertions
   // ****************************************
   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_b);

   sequence wr_all_s;
      wr_ctrl1 && i_wdata[`LEC1_BIT_FLUSH_ALL] && st_ff == lec1_pkg::LEC1_ST_IDLE &&
      !all_pend_ff && !mstp_pend_ff && port_pend_ff == 3'h0 && !opt_none &&
      !(i_wr && hit(i_addr, `LEC1_ADDR_CTRL2));
   endsequence

   sequence all_started_s;
      o_flush_start && o_flush_cmd.kind == lec1_pkg::LEC1_K_ALL;
   endsequence

   sequence all_done_s;
      st_ff == lec1_pkg::LEC1_ST_BUSY && cmd_ff.kind == lec1_pkg::LEC1_K_ALL &&
      i_flush_done && !(wr_ctrl1 && i_wdata[`LEC1_BIT_FLUSH_ALL]);
   endsequence

   sequence mstp_done_s;
      st_ff == lec1_pkg::LEC1_ST_BUSY && cmd_ff.kind == lec1_pkg::LEC1_K_MSTP &&
      i_flush_done && !(wr_ctrl1 && i_wdata[`LEC1_BIT_FLUSH_MSTP]);
   endsequence

   learn_gate_a: assert property (o_learn |-> !$past(ctrl_ff[`LEC1_BIT_LEARN_DIS])) // RULE1
      else $error("Learning while unicast learning is disabled.");
   self_drop_a: assert property (i_frame.valid && self_hit |=> o_drop) // RULE2
      else $error("Self-addressed frame not dropped.");
   self_global_a: assert property (i_frame.valid && !ctrl_ff[`LEC1_BIT_SELF_FILT] && // RULE3
      !i_frame.sa[`LEC1_SA_MC_BIT] |=> !o_drop)
      else $error("Frame dropped with self filtering globally off.");
   self_port_a: assert property (i_frame.valid && !i_port_self_filt_en[i_frame.port] && // RULE3
      !i_frame.sa[`LEC1_SA_MC_BIT] |=> !o_drop)
      else $error("Frame dropped on a port with self filtering off.");
   flush_all_a: assert property (wr_all_s |=> all_pend_ff ##1 all_started_s) // RULE4
      else $error("Table flush did not start two cycles after its trigger.");
   all_clear_a: assert property (all_done_s |=> !all_pend_ff) // RULE4
      else $error("Table flush bit did not clear after its flush ended.");
   flush_opt_a: assert property (o_flush_start |-> // RULE5 RULE6
      o_flush_cmd.opt == $past(opt_ff) && o_flush_cmd.opt != `LEC1_OPT_NONE)
      else $error("Flush started with wrong or empty option.");
   none_retire_a: assert property (st_ff == lec1_pkg::LEC1_ST_IDLE && all_pend_ff && // RULE6
      opt_none && !(wr_ctrl1 && i_wdata[`LEC1_BIT_FLUSH_ALL]) |=>
      !all_pend_ff && !o_flush_start)
      else $error("Flush with option none did not retire without a start.");
   flush_mstp_a: assert property ($rose(mstp_pend_ff) |-> // RULE7
      $past(wr_ctrl1 && i_wdata[`LEC1_BIT_FLUSH_MSTP]))
      else $error("Spanning tree flush pending without a trigger.");
   mstp_clear_a: assert property (mstp_done_s |=> !mstp_pend_ff) // RULE7
      else $error("Spanning tree flush bit did not clear after its flush ended.");
   mc_drop_a: assert property (i_frame.valid && i_frame.sa[`LEC1_SA_MC_BIT] && // RULE8
      !ctrl_ff[`LEC1_BIT_MC_FWD] |=> o_drop && !o_learn)
      else $error("Multicast source frame not dropped.");
   age_ctrl_a: assert property (wr_ctrl1 |=> // RULE9 RULE10
      o_age_en == $past(i_wdata[`LEC1_BIT_AGE_EN]) &&
      o_fast_age == $past(i_wdata[`LEC1_BIT_FAST_AGE]))
      else $error("Aging outputs do not follow the written value.");
   link_flush_a: assert property ($rose(|port_pend_ff) |-> // RULE11
      $past(ctrl_ff[`LEC1_BIT_LINK_FLUSH]))
      else $error("Port flush pending while link-down flush is off.");
   port_flush_a: assert property ((|link_down) && ctrl_ff[`LEC1_BIT_LINK_FLUSH] |=> // RULE11
      (port_pend_ff & $past(link_down)) == $past(link_down))
      else $error("Link-down flush not pending for a port that went down.");
   busy_read_a: assert property (i_rd && hit(i_addr, `LEC1_ADDR_CTRL1) |=> // RULE12
      o_rdata[`LEC1_BIT_FLUSH_ALL] == $past(all_pend_ff))
      else $error("Flush bit read does not show flush progress.");
   mstp_read_a: assert property (i_rd && hit(i_addr, `LEC1_ADDR_CTRL1) |=> // RULE12
      o_rdata[`LEC1_BIT_FLUSH_MSTP] == $past(mstp_pend_ff))
      else $error("Spanning tree flush bit read does not show flush progress.");

endmodule

// ---- verification/tb_lec1_ctrl.sv ----
// Self-checking testbench for the lookup engine control block.
`timescale 1ns/1ps
`include "lec1_regs.svh"
module tb;
   logic i_clk, i_rst_b, i_wr, i_rd, i_flush_done, pf, pr;
   logic o_drop, o_learn, o_age_en, o_fast_age, o_flush_start;
   logic [15:0] i_addr;
   logic [7:0] i_wdata, o_rdata, ctl;
   logic [47:0] i_switch_mac;
   logic [2:0] i_port_self_filt_en, i_link_up;
   lec1_pkg::lec1_frame_t i_frame;
   lec1_pkg::lec1_flush_cmd_t o_flush_cmd, cx;
   lec1_pkg::lec1_flush_cmd_t qc[$];
   logic [1:0] qf[$];
   logic [7:0] qr[$];
   int fails, samples_checked, starts, i, s0;
   integer seed;

   lec1_ctrl u_lec1_ctrl (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_addr(i_addr),
      .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_frame(i_frame),
      .i_switch_mac(i_switch_mac), .i_port_self_filt_en(i_port_self_filt_en),
      .i_link_up(i_link_up), .i_flush_done(i_flush_done), .o_drop(o_drop),
      .o_learn(o_learn), .o_age_en(o_age_en), .o_fast_age(o_fast_age),
      .o_flush_start(o_flush_start), .o_flush_cmd(o_flush_cmd));

   initial begin
      i_clk = 1'b0;
      forever #25 i_clk = ~i_clk;
   end

   // ****************************************
   // Checking
   // ****************************************
   task automatic tally(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // One compare per kind of result, all counted by the same tally.
   task automatic cmp_frame(input logic [1:0] got, input logic [1:0] exp);
      tally({30'h0, got}, {30'h0, exp});
   endtask

   task automatic cmp_rdata(input logic [7:0] got, input logic [7:0] exp);
      tally({24'h0, got}, {24'h0, exp});
   endtask

   task automatic cmp_cmd(input lec1_pkg::lec1_flush_cmd_t got,
         input lec1_pkg::lec1_flush_cmd_t exp);
      tally({24'h0, got}, {24'h0, exp});
   endtask

   task automatic cmp_level(input logic [1:0] got, input logic [1:0] exp);
      tally({30'h0, got}, {30'h0, exp});
   endtask

   task automatic cmp_count(input logic [31:0] got, input logic [31:0] exp);
      tally(got, exp);
   endtask

   task automatic conclude();
      $display("fails=%0d samples_checked=%0d", fails, samples_checked);
      if (fails == 0 && samples_checked > 0) $display("STATUS OK");
      else $display("STATUS NOT OK");
      $finish;
   endtask

   always @(posedge i_clk) begin
      pf <= i_frame.valid;
      pr <= i_rd;
   end

   // Registered results are taken at the falling edge, where they have settled.
   always @(negedge i_clk) if (i_rst_b) begin
      if (pf) cmp_frame({o_drop, o_learn}, qf.size() ? qf.pop_front() : 2'bxx);
      if (pr) cmp_rdata(o_rdata, qr.size() ? qr.pop_front() : 8'hxx);
      if (o_flush_start) begin
         starts++;
         cx = qc.size() ? qc.pop_front() : 'x;
         cmp_cmd(o_flush_cmd, cx);
      end
   end

   // ****************************************
   // Bus and stimulus tasks
   // ****************************************
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge i_clk);
      i_wr <= 1'b1;
      i_addr <= a;
      i_wdata <= d;
      @(posedge i_clk);
      i_wr <= 1'b0;
   endtask

   task automatic rd(input logic [15:0] a, input logic [7:0] e);
      @(posedge i_clk);
      i_rd <= 1'b1;
      i_addr <= a;
      qr.push_back(e);
      @(posedge i_clk);
      i_rd <= 1'b0;
   endtask

   task automatic frame();
      lec1_pkg::lec1_frame_t f;
      logic d;
      f.valid = 1'b1;
      f.sa = 48'({$random(seed), $random(seed)});
      f.port = 2'({$random(seed)} % 3);
      if (f.sa[1:0] == 2'h0) f.sa = i_switch_mac;
      if (f.sa[3:2] == 2'h0) f.sa[`LEC1_SA_MC_BIT] = 1'b1;
      @(posedge i_clk);
      d = (ctl[6] & i_port_self_filt_en[f.port] & (f.sa == i_switch_mac)) |
          (f.sa[`LEC1_SA_MC_BIT] & !ctl[3]);
      qf.push_back({d, !d & !f.sa[`LEC1_SA_MC_BIT] & !ctl[7]});
      i_frame <= f;
   endtask

   task automatic wstart(input int s, input int e);
      int k;
      for (k = 0; k < 20 && starts == s; k++) @(posedge i_clk);
      cmp_count(starts, e);
   endtask

   task automatic done();
      @(posedge i_clk);
      i_flush_done <= 1'b1;
      @(posedge i_clk);
      i_flush_done <= 1'b0;
   endtask

   task automatic flush(input int b, input lec1_pkg::lec1_kind_t kind, input logic [1:0] opt);
      int s;
      s = starts;
      wr(`LEC1_ADDR_CTRL2, {4'h0, opt, 2'h0});
      if (opt != 2'h0) qc.push_back('{kind, opt, 3'h0});
      wr(`LEC1_ADDR_CTRL1, ctl | (8'h01 << b));
      wstart(s, s + int'(opt != 2'h0));
      if (opt != 2'h0) begin
         rd(`LEC1_ADDR_CTRL1, ctl | (8'h01 << b));
         done();
      end
      rd(`LEC1_ADDR_CTRL1, ctl);
   endtask

   // ****************************************
   // Main sequence
   // ****************************************
   initial begin
      seed = 32'hdee7_a774;
      {i_rst_b, i_wr, i_rd, i_flush_done, i_addr, i_wdata} = '0;
      i_frame = '0;
      i_switch_mac = 48'h0200_1234_5678;
      i_port_self_filt_en = 3'b101;
      i_link_up = 3'b111;
      ctl = `LEC1_CTRL1_RST;
      repeat (2) @(posedge i_clk);
      i_rst_b <= 1'b1;
      rd(`LEC1_ADDR_CTRL1, 8'h0c);
      rd(`LEC1_ADDR_CTRL2, 8'h00);
      cmp_level({o_age_en, o_fast_age}, 2'b10);
      wr(16'h0313, 8'hff);
      rd(16'h0313, 8'h00);
      wr(`LEC1_ADDR_CTRL2, 8'hff);
      rd(`LEC1_ADDR_CTRL2, 8'h0c);
      rd(`LEC1_ADDR_CTRL1, ctl);
      for (i = 0; i < 16; i++) begin
         ctl = 8'($random(seed)) & 8'hce;
         wr(`LEC1_ADDR_CTRL1, ctl);
         rd(`LEC1_ADDR_CTRL1, ctl);
         cmp_level({o_age_en, o_fast_age}, ctl[2:1]);
         i_port_self_filt_en <= 3'($random(seed));
         repeat (16) frame();
         @(posedge i_clk);
         i_frame <= '0;
      end
      ctl = 8'h0c;
      wr(`LEC1_ADDR_CTRL1, ctl);
      for (i = 0; i < 4; i++) flush(5, lec1_pkg::LEC1_K_ALL, 2'(i));
      for (i = 0; i < 4; i++) flush(4, lec1_pkg::LEC1_K_MSTP, 2'(i));
      // A port going down only flushes while the link-down flush bit is set.
      ctl = 8'h0d;
      wr(`LEC1_ADDR_CTRL1, ctl);
      wr(`LEC1_ADDR_CTRL2, 8'h04);
      s0 = starts;
      qc.push_back('{lec1_pkg::LEC1_K_PORT, 2'h1, 3'b010});
      i_link_up <= 3'b101;
      wstart(s0, s0 + 1);
      done();
      ctl = 8'h0c;
      wr(`LEC1_ADDR_CTRL1, ctl);
      s0 = starts;
      i_link_up <= 3'b100;
      wstart(s0, s0);
      // A reset in mid-run must bring back the power-up values.
      wr(`LEC1_ADDR_CTRL1, 8'h83);
      wr(`LEC1_ADDR_CTRL2, 8'h08);
      @(posedge i_clk);
      i_rst_b <= 1'b0;
      repeat (2) @(posedge i_clk);
      i_rst_b <= 1'b1;
      ctl = `LEC1_CTRL1_RST;
      rd(`LEC1_ADDR_CTRL1, ctl);
      rd(`LEC1_ADDR_CTRL2, 8'h00);
      cmp_level({o_age_en, o_fast_age}, 2'b10);
      conclude();
   end

   initial begin
      #(50 * 20000);
      fails++;
      conclude();
   end
endmodule
